// File: octal_dac_serial_command_decoder.v
// Serial command decoder for an eight-channel 8-bit DAC
// What this block does
// - 16-bit word: 2 ignored, select, command, payload
// - Command 000 only shifts, changes nothing
// - Command 001 zeroes all input and DAC registers
// - Command 010 shutdown; zero bits disable buffers
// - Leave shutdown on reset, clear, 100, 110
// - 011 with select high 0: falling phase, update
// - 011 with select high 1: rising phase latched
// - Rising phase command also copies input to DAC
// - Reset phase is falling edge
// - Command 100 loads payload into all DACs
// - Command 101 loads selected input register only
// - Command 110 loads selected input and DAC
// - Command 111 copies all input registers to DAC
// - Execute on chip select rising edge
// - Sample data on rising clock while selected
// - Serial out lags 16 or 16.5 cycles, driven
// - Load strobe low makes DAC follow input
`timescale 1ns/1ps
`include "dac_cmd_defines.vh"

module octal_dac_serial_command_decoder (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Serial link pins from host
    input wire sclk,
    input wire cs_n,
    input wire din,
    input wire load_strobe_pin_n,
    // Serial output, always driven
    output reg dout_ff,
    // DAC codes, channel one in low byte
    output reg [63:0] dac_code_ff,
    // Output buffer enables, one per channel
    output reg [7:0] buf_en_ff,
    // Current serial output phase, 1 = rising
    output reg phase_ff,
    // Shutdown state
    output reg shutdown_ff
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    wire sclk_s; // Synchronised serial clock
    wire cs_n_s; // Synchronised chip select
    wire din_s; // Synchronised data
    wire load_strobe_pin_n_s; // Synchronised load strobe
    reg sclk_d_ff; // Previous serial clock level
    reg cs_n_d_ff; // Previous chip select level
    reg [15:0] shift_ff; // Input shift register
    reg [15:0] nxt_shift;
    reg [63:0] in_reg_ff; // Eight input registers
    reg [63:0] nxt_in_reg;
    reg [63:0] nxt_dac_code;
    reg [7:0] nxt_buf_en;
    reg nxt_phase;
    reg nxt_shutdown;
    reg nxt_dout;
    reg out_bit_ff; // Outgoing bit kept from rise to falling edge
    reg nxt_out_bit;
    reg [2:0] cmd; // Decoded command field
    reg [2:0] sel; // Decoded channel select
    reg [7:0] pay; // Decoded payload
    wire sclk_rise;
    wire sclk_fall;
    wire cs_rise;

    // Channel select to one-hot mask, used for input and DAC writes
    function [7:0] chan_mask;
        input [2:0] s;
        begin
            chan_mask = 8'h01 << s;
        end
    endfunction

    // Replace one byte lane of a packed 64-bit bank
    function [63:0] put_byte;
        input [63:0] bank;
        input [2:0] s;
        input [7:0] val;
        integer k;
        begin
            put_byte = bank;
            for (k = 0; k < 8; k = k + 1) begin
                if (chan_mask(s) == (8'h01 << k))
                    put_byte[k*8 +: 8] = val;
            end
        end
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    in_sync u_sync_sclk (
        .clk(clk),
        .rst(rst),
        .async_in(sclk),
        .sync_out_ff(sclk_s)
    );
    in_sync u_sync_cs (
        .clk(clk),
        .rst(rst),
        .async_in(cs_n),
        .sync_out_ff(cs_n_s)
    );
    in_sync u_sync_din (
        .clk(clk),
        .rst(rst),
        .async_in(din),
        .sync_out_ff(din_s)
    );
    in_sync u_sync_load_strobe_pin (
        .clk(clk),
        .rst(rst),
        .async_in(load_strobe_pin_n),
        .sync_out_ff(load_strobe_pin_n_s)
    );

    // ----------------------------------------
    // Edge detection on synchronised levels
    // ----------------------------------------
    // Chip select delayed with data so the last bit is seen first
    assign sclk_rise = sclk_s & ~sclk_d_ff;
    assign sclk_fall = ~sclk_s & sclk_d_ff;
    assign cs_rise = cs_n_s & ~cs_n_d_ff;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always @* begin
        nxt_shift = shift_ff;
        nxt_in_reg = in_reg_ff;
        nxt_dac_code = dac_code_ff;
        nxt_buf_en = buf_en_ff;
        nxt_phase = phase_ff;
        nxt_shutdown = shutdown_ff;
        nxt_dout = dout_ff;
        nxt_out_bit = out_bit_ff;
        // Field split, MSB first, top two bits ignored
        sel = shift_ff[`SEL_MSB:`SEL_LSB];
        cmd = shift_ff[`CMD_MSB:`CMD_LSB];
        pay = shift_ff[`PAY_MSB:`PAY_LSB];
        // Shift only while selected
        if (!cs_n_s && sclk_rise) begin
            nxt_shift = {shift_ff[14:0], din_s};
            // Bit 15 before the shift, kept for the falling edge
            nxt_out_bit = shift_ff[15];
        end
        // Bit 15 leaves on chosen edge; held while deselected
        // Rising phase: at the shift edge gives 16 cycles lag
        // Falling phase: the kept bit half a cycle later, 16.5;
        // reading bit 15 after the shift would lag only 15.5
        if (!cs_n_s) begin
            if (phase_ff == `PHASE_RISE && sclk_rise)
                nxt_dout = shift_ff[15];
            else if (phase_ff == `PHASE_FALL && sclk_fall)
                nxt_dout = out_bit_ff;
        end
        // Execute only on chip select rising edge
        if (cs_rise) begin
            case (cmd)
                `CMD_NOP: begin
                    // Pass-through only
                end
                `CMD_CLEAR: begin
                    nxt_in_reg = {8{`CODE_ZERO}};
                    nxt_dac_code = {8{`CODE_ZERO}};
                    nxt_shutdown = 1'b0;
                    nxt_buf_en = `BUF_ALL_ON;
                end
                `CMD_SHUTDOWN: begin
                    nxt_shutdown = 1'b1;
                    nxt_buf_en = pay;
                end
                `CMD_PHASE: begin
                    // Select high bit picks phase
                    nxt_phase = sel[2] ? `PHASE_RISE : `PHASE_FALL;
                    nxt_dac_code = in_reg_ff;
                end
                `CMD_LOAD_ALL: begin
                    nxt_dac_code = {8{pay}};
                    nxt_shutdown = 1'b0;
                    nxt_buf_en = `BUF_ALL_ON;
                end
                `CMD_LOAD_IN: begin
                    nxt_in_reg = put_byte(in_reg_ff, sel, pay);
                end
                `CMD_LOAD_BOTH: begin
                    nxt_in_reg = put_byte(in_reg_ff, sel, pay);
                    nxt_dac_code = put_byte(dac_code_ff, sel, pay);
                    nxt_shutdown = 1'b0;
                    nxt_buf_en = `BUF_ALL_ON;
                end
                `CMD_SW_UPDATE: begin
                    nxt_dac_code = in_reg_ff;
                end
                default: begin
                    nxt_shift = nxt_shift;
                end
            endcase
        end
        // Transparent DAC while strobe low, after any input write
        // Follows new input values the same edge
        if (!load_strobe_pin_n_s) begin
            nxt_dac_code = nxt_in_reg;
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    // Power-on state: codes zero, buffers on, falling phase
    always @(posedge clk) begin
        if (rst) begin
            // High like the synchroniser, so no rise follows reset
            sclk_d_ff <= 1'b1;
            cs_n_d_ff <= 1'b1;
            shift_ff <= `WORD_ZERO;
            in_reg_ff <= {8{`CODE_ZERO}};
            dac_code_ff <= {8{`CODE_ZERO}};
            buf_en_ff <= `BUF_ALL_ON;
            phase_ff <= `PHASE_FALL;
            shutdown_ff <= 1'b0;
            dout_ff <= 1'b0;
            out_bit_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_n_d_ff <= cs_n_s;
            shift_ff <= nxt_shift;
            in_reg_ff <= nxt_in_reg;
            dac_code_ff <= nxt_dac_code;
            buf_en_ff <= nxt_buf_en;
            phase_ff <= nxt_phase;
            shutdown_ff <= nxt_shutdown;
            dout_ff <= nxt_dout;
            out_bit_ff <= nxt_out_bit;
        end
    end

endmodule // octal_dac_serial_command_decoder

// File: dac_cmd_defines.vh
// Constants for the octal DAC serial command decoder
`ifndef DAC_CMD_DEFINES_VH
`define DAC_CMD_DEFINES_VH

// ----------------------------------------
// Command word layout
// ----------------------------------------
`define WORD_BITS 16
`define SEL_MSB 13
`define SEL_LSB 11
`define CMD_MSB 10
`define CMD_LSB 8
`define PAY_MSB 7
`define PAY_LSB 0

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_NOP 3'h0
`define CMD_CLEAR 3'h1
`define CMD_SHUTDOWN 3'h2
`define CMD_PHASE 3'h3
`define CMD_LOAD_ALL 3'h4
`define CMD_LOAD_IN 3'h5
`define CMD_LOAD_BOTH 3'h6
`define CMD_SW_UPDATE 3'h7

// ----------------------------------------
// Reset values and phase codes
// ----------------------------------------
`define CODE_ZERO 8'h00
`define BUF_ALL_ON 8'hFF
`define PHASE_FALL 1'b0
`define PHASE_RISE 1'b1
`define WORD_ZERO 16'h0000

`endif

// File: in_sync.v
// Two-flop synchroniser for one asynchronous input
`timescale 1ns/1ps

module in_sync (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Asynchronous level in, synchronised level out
    input wire async_in,
    output reg sync_out_ff
);

    reg meta_ff; // First stage, read only by second stage

    // ----------------------------------------
    // Two stages
    // ----------------------------------------
    // Reset to high: select and strobe idle high, so no false
    // select or load pulse follows reset; edge detectors match it
    always @(posedge clk) begin
        if (rst) begin
            meta_ff <= 1'b1;
            sync_out_ff <= 1'b1;
        end else begin
            meta_ff <= async_in;
            sync_out_ff <= meta_ff;
        end
    end

endmodule // in_sync

// File: dac_chk.sv
// Port assertions for the DAC command decoder
`timescale 1ns/1ps
module dac_chk (
    // Clock and reset
    input logic clk,
    input logic rst,
    // Serial pins
    input logic sclk,
    input logic cs_n,
    input logic din,
    input logic load_strobe_pin_n,
    // Decoder outputs
    input logic dout_ff,
    input logic [63:0] dac_code_ff,
    input logic [7:0] buf_en_ff,
    input logic phase_ff,
    input logic shutdown_ff
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Power-on state seen at the first edge after release
    a_reset_vals: assert property ($fell(rst) |->
        dac_code_ff == 64'h0 && buf_en_ff == 8'hFF && !phase_ff
        && !shutdown_ff)
        else $error("bad state after reset");
    a_dout_idle: assert property (cs_n [*6] |->
        $stable(dout_ff))
        else $error("serial out moved while deselected");
    // Sync delay allows a few cycles of pin history
    a_dout_frame: assert property ($changed(dout_ff) |->
        !$past(cs_n, 3) || !$past(cs_n, 4) || !$past(cs_n, 5))
        else $error("serial out moved outside a frame");
    a_codes_idle: assert property (
        (cs_n && load_strobe_pin_n) [*8] |-> $stable(dac_code_ff))
        else $error("codes moved with no command");
    a_phase_exec: assert property ($changed(phase_ff) |->
        cs_n)
        else $error("phase moved mid frame");
    a_buf_exec: assert property ($changed(buf_en_ff) |->
        cs_n)
        else $error("buffer enables moved mid frame");
    a_run_bufs_on: assert property (!shutdown_ff |->
        buf_en_ff == 8'hFF)
        else $error("buffer off outside shutdown");
    a_shut_exit: assert property ($fell(shutdown_ff) |->
        cs_n)
        else $error("shutdown left mid frame");
    // Main scenarios reached
    c_shutdown: cover property ($rose(shutdown_ff));
    c_rise_phase: cover property ($rose(phase_ff));
    c_follow: cover property (!load_strobe_pin_n && $changed(dac_code_ff));
endmodule // dac_chk

// File: dac_host_model.sv
// Host serial master model driving the command pins
`timescale 1ns/1ps
module dac_host_model (
    // Bench clock
    input logic clk,
    // Serial pins toward the decoder
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // Idle: deselected, serial clock parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // Half period of the link clock in bench cycles: 80 ns period
    localparam int HALF = 4;
    // Frame of nb bits, MSB first; chained words go farthest first
    task automatic send_frame(input logic [47:0] f, input int nb);
        @(negedge clk) cs_n = 1'b0;
        repeat (HALF) @(negedge clk);
        for (int i = nb - 1; i >= 0; i--) begin
            din = f[i];
            repeat (HALF) @(negedge clk);
            sclk = 1'b1;
            repeat (HALF) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        cs_n = 1'b1;
        // Data line carries junk between frames
        din = ~din;
        repeat (12) @(negedge clk);
    endtask
    // One 16-bit command word for a lone device
    task automatic send_word(input logic [15:0] w);
        send_frame({32'h0, w}, 16);
    endtask
endmodule // dac_host_model

// File: octal_dac_serial_command_decoder_bench.sv
// Self-checking bench for the DAC command decoder
`timescale 1ns/1ps
`include "dac_cmd_defines.vh"
module octal_dac_serial_command_decoder_bench;
    // Clock, reset and pins
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strobe_n = 1'b1;
    logic sclk, cs_n, din, dout_ff, phase_ff, shutdown_ff;
    logic [63:0] dac_code_ff, inr, dac;
    logic [7:0] buf_en_ff, bf, seed;
    logic ph, sd;
    // Expected outputs, oldest first
    logic [73:0] exp_q[$];
    // Expected serial out bits, oldest first
    logic bit_q[$];
    int error_cnt = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    dac_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din));
    octal_dac_serial_command_decoder u_dut (.clk(clk), .rst(rst),
        .sclk(sclk), .cs_n(cs_n), .din(din), .load_strobe_pin_n(strobe_n),
        .dout_ff(dout_ff), .dac_code_ff(dac_code_ff), .buf_en_ff(buf_en_ff),
        .phase_ff(phase_ff), .shutdown_ff(shutdown_ff));
    // ---
    // Helpers
    // ---
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [73:0] want, input logic [73:0] got);
        cmp_count++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic chk_dout(input logic want, input logic got);
        cmp_count++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: serial out %b want %b", $time,
                got, want);
        end
    endtask
    // Serial out shows each sent bit 17 link clock rises later
    task automatic note_bits(input logic [47:0] f, input int nb);
        for (int b = nb - 1; b >= 0; b--) begin
            bit_q.push_back(f[b]);
        end
    endtask
    // Reference model of one command at chip-select rise
    task automatic apply(input logic [15:0] w);
        int s;
        s = w[13:11];
        case (w[10:8])
            `CMD_CLEAR: begin
                inr = 64'h0;
                dac = 64'h0;
            end
            `CMD_SHUTDOWN: begin
                sd = 1'b1;
                bf = w[7:0];
            end
            `CMD_PHASE: begin
                ph = w[13];
                dac = inr;
            end
            `CMD_LOAD_ALL: dac = {8{w[7:0]}};
            `CMD_LOAD_IN: inr[s*8+:8] = w[7:0];
            `CMD_LOAD_BOTH: begin
                inr[s*8+:8] = w[7:0];
                dac[s*8+:8] = w[7:0];
            end
            `CMD_SW_UPDATE: dac = inr;
            default: ;
        endcase
        // Only these wake the part; phase alone does not
        if (w[10:8] == `CMD_CLEAR || w[10:8] == `CMD_LOAD_ALL ||
            w[10:8] == `CMD_LOAD_BOTH) begin
            sd = 1'b0;
            bf = 8'hFF;
        end
        if (!strobe_n) begin
            dac = inr;
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ---
    // Processes
    // ---
    // Watcher: results settle a few cycles after chip-select rise
    initial begin
        wait (rst === 1'b0);
        forever begin
            @(posedge cs_n);
            repeat (8) @(negedge clk);
            chk(exp_q.pop_front(), {dac_code_ff, buf_en_ff, phase_ff,
                shutdown_ff});
        end
    end
    // Serial out watcher: level standing at each link clock rise,
    // set by the previous rise or fall in either phase
    initial begin
        wait (rst === 1'b0);
        forever begin
            @(posedge sclk);
            chk_dout(bit_q.pop_front(), dout_ff);
        end
    end
    // Driver: every code three times, random fields
    initial begin
        logic [15:0] w;
        logic [47:0] f;
        logic [2:0] c;
        seed = 8'h45;
        // Serial path starts all zero after reset
        for (int b = 0; b < 17; b++) begin
            bit_q.push_back(1'b0);
        end
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        {inr, dac, bf, ph, sd} = {128'h0, 8'hFF, 2'b00};
        chk({dac, bf, ph, sd}, {dac_code_ff, buf_en_ff, phase_ff,
            shutdown_ff});
        for (int i = 0; i < 24; i++) begin
            // Strobe low only while no input-only load is sent
            strobe_n = !(i >= 17 && i <= 19);
            c = 3'(i * 5 + 5);
            seed = lfsr(seed);
            w = {seed[7:6], i[3], seed[4:3], c, 8'h00};
            seed = lfsr(seed);
            w[7:0] = seed;
            apply(w);
            exp_q.push_back({dac, bf, ph, sd});
            note_bits({32'h0, w}, 16);
            u_host.send_word(w);
        end
        // Chained frame: far clear and middle no-op only pass through
        seed = lfsr(seed);
        w = {2'b00, seed[2:0], `CMD_LOAD_BOTH, seed};
        f = {2'b00, 3'h0, `CMD_CLEAR, 8'h00,
            2'b00, 3'h0, `CMD_NOP, 8'h00, w};
        apply(w);
        exp_q.push_back({dac, bf, ph, sd});
        note_bits(f, 48);
        u_host.send_frame(f, 48);
        repeat (20) @(negedge clk);
        report_and_stop();
    end
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule // octal_dac_serial_command_decoder_bench
bind octal_dac_serial_command_decoder dac_chk u_chk (.clk(clk), .rst(rst),
    .sclk(sclk), .cs_n(cs_n), .din(din),
    .load_strobe_pin_n(load_strobe_pin_n), .dout_ff(dout_ff),
    .dac_code_ff(dac_code_ff), .buf_en_ff(buf_en_ff), .phase_ff(phase_ff),
    .shutdown_ff(shutdown_ff));
